/* logic/ascc_defines.svh */
// Offsets, reset values, field positions and timing counts of the audio serial clock block
// Assumes a 125 MHz system clock
`ifndef ASCC_DEFINES_SVH
`define ASCC_DEFINES_SVH

`define ASCC_ADDR_MASTER_RATE 8'h14
`define ASCC_ADDR_MONITOR_STS 8'h15
`define ASCC_ADDR_CLOCK_SRC 8'h16

`define ASCC_RST_MASTER_RATE 8'h48
`define ASCC_RST_MONITOR_STS 8'hFF
`define ASCC_RST_CLOCK_SRC 8'h10

`define ASCC_RATE_MSB 7
`define ASCC_RATE_LSB 4
`define ASCC_RATIO_MSB 3
`define ASCC_RATIO_LSB 0

`define ASCC_CODE_INVALID 4'hF
`define ASCC_RATE_CODE_MAX 4'h8
`define ASCC_RATIO_CODE_MAX 4'hC

`define ASCC_CLK_HZ 32'h0773_5940
`define ASCC_CLK_PERIOD_NS 32'h0000_0008
`define ASCC_FRAME_TIMEOUT_NS 32'h0004_2680
`define ASCC_RATE_TOL_PCT 32'h0000_0002

`endif

/* logic/ascc_pkg.sv */
// Types shared by the audio serial clock block
// Offsets and timing live in ascc_defines.svh
package ascc_pkg;
  typedef logic [7:0] ascc_addr_t;
  typedef logic [7:0] ascc_byte_t;
  typedef logic [3:0] ascc_code_t;
  typedef logic [11:0] ascc_count_t;

  typedef struct packed {
    logic rootSrcRef;
    logic refFreqFromRatio;
    logic [2:0] refRatioSel;
    logic rsvHigh;
    logic invertBitClk;
    logic rsvLow;
  } ascc_clock_source_config_s;
endpackage

/* logic/ascc_mon_if.sv */
// Carrier from the bus-clock monitor to the control logic
// Word changes together with the toggle, once per frame, in the bit clock domain
`timescale 1ns/1ns
`default_nettype none
interface ascc_mon_if;
  logic frameToggle;
  ascc_pkg::ascc_count_t ratioCount;

  modport mon (output frameToggle, output ratioCount);
  modport ctl (input frameToggle, input ratioCount);
endinterface
`default_nettype wire

/* logic/ascc_link_monitor.sv */
// Bus-clock monitor on the incoming bit clock
// Assumes frame sync is launched in the bit clock domain; clock may stop between frames
`timescale 1ns/1ns
`default_nettype none
module ascc_link_monitor
  import ascc_pkg::*;
(
  // Link clock and reset
  input wire logic bitClk,
  input wire logic rstn,
  // Bus pin
  input wire logic frameSyncIn,
  // To the control domain
  ascc_mon_if.mon mon
);
  logic rstSync1_reg;
  logic rstSync2_reg;
  logic fsPrev_reg;
  logic seen_reg;
  logic toggle_reg;
  ascc_count_t bitCnt_reg;
  ascc_count_t ratioCount_reg;
  logic frameEdge;

  // Reset into the link domain
  always_ff @(posedge bitClk)
  begin
    rstSync1_reg <= rstn;
    rstSync2_reg <= rstSync1_reg;
  end

  assign frameEdge = frameSyncIn && !fsPrev_reg;

  always_ff @(posedge bitClk)
  begin
    if (!rstSync2_reg)
    begin
      fsPrev_reg <= 1'b0;
      seen_reg <= 1'b0;
      toggle_reg <= 1'b0;
      bitCnt_reg <= 12'h001;
      ratioCount_reg <= 12'h000;
    end
    else
    begin
      fsPrev_reg <= frameSyncIn;
      if (frameEdge)
      begin
        // Bit clocks per frame, first frame after reset only primes
        bitCnt_reg <= 12'h001;
        seen_reg <= 1'b1;
        if (seen_reg)
        begin
          ratioCount_reg <= bitCnt_reg;
          toggle_reg <= !toggle_reg;
        end
      end
      else if (bitCnt_reg != 12'hFFF)
      begin
        bitCnt_reg <= bitCnt_reg + 12'h001;
      end
    end
  end

  assign mon.frameToggle = toggle_reg;
  assign mon.ratioCount = ratioCount_reg;
endmodule
`default_nettype wire

/* logic/ascc_clock_config.sv */
// Audio serial clock configuration, master clock generation and bus-clock monitor status
// Assumes register accesses come from the control port logic in the clk domain
`timescale 1ns/1ns
`default_nettype none
`include "ascc_defines.svh"

module ascc_clock_config
  import ascc_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT_CYC = `ASCC_FRAME_TIMEOUT_NS / `ASCC_CLK_PERIOD_NS
)
(
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire ascc_pkg::ascc_addr_t regAddr,
  input wire logic regWrEn,
  input wire ascc_pkg::ascc_byte_t regWrData,
  output ascc_pkg::ascc_byte_t regRdData,
  // Master configuration bits
  input wire logic masterSlaveSelect,
  input wire logic autoClkCfgOn,
  input wire logic autoPllDisable,
  input wire logic rateFamilySelect,
  input wire logic [2:0] refFixedFreqSelect,
  // Bus clock pins
  input wire logic bitClkIn,
  output logic bitClkOut,
  output logic bitClkOe,
  input wire logic frameSyncIn,
  output logic frameSyncOut,
  output logic frameSyncOe,
  // Clock tree settings
  output logic rootUsesRef,
  output ascc_pkg::ascc_count_t refRatioValue,
  output logic [31:0] refFreqHz
);
  import ascc_pkg::*;

  function automatic logic [19:0] rateHz(input logic [3:0] code, input logic fam44);
    logic [19:0] hz;
    hz = 20'h0_0000;
    case (code)
      4'h0: hz = fam44 ? 20'd7350 : 20'd8000;
      4'h1: hz = fam44 ? 20'd14700 : 20'd16000;
      4'h2: hz = fam44 ? 20'd22050 : 20'd24000;
      4'h3: hz = fam44 ? 20'd29400 : 20'd32000;
      4'h4: hz = fam44 ? 20'd44100 : 20'd48000;
      4'h5: hz = fam44 ? 20'd88200 : 20'd96000;
      4'h6: hz = fam44 ? 20'd176400 : 20'd192000;
      4'h7: hz = fam44 ? 20'd352800 : 20'd384000;
      4'h8: hz = fam44 ? 20'd705600 : 20'd768000;
      default: hz = 20'h0_0000;
    endcase
    return hz;
  endfunction

  function automatic ascc_count_t bitRatio(input logic [3:0] code);
    ascc_count_t r;
    r = 12'h000;
    case (code)
      4'h0: r = 12'h010;
      4'h1: r = 12'h018;
      4'h2: r = 12'h020;
      4'h3: r = 12'h030;
      4'h4: r = 12'h040;
      4'h5: r = 12'h060;
      4'h6: r = 12'h080;
      4'h7: r = 12'h0C0;
      4'h8: r = 12'h100;
      4'h9: r = 12'h180;
      4'hA: r = 12'h200;
      4'hB: r = 12'h400;
      4'hC: r = 12'h800;
      default: r = 12'h000;
    endcase
    return r;
  endfunction

  function automatic ascc_count_t refRatio(input logic [2:0] sel);
    ascc_count_t r;
    r = 12'h000;
    case (sel)
      3'h0: r = 12'h040;
      3'h1: r = 12'h100;
      3'h2: r = 12'h180;
      3'h3: r = 12'h200;
      3'h4: r = 12'h300;
      3'h5: r = 12'h400;
      3'h6: r = 12'h600;
      default: r = 12'h900;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] fixedRefHz(input logic [2:0] sel);
    logic [31:0] hz;
    hz = 32'h0000_0000;
    case (sel)
      3'h0: hz = 32'd12000000;
      3'h1: hz = 32'd12288000;
      3'h2: hz = 32'd13000000;
      3'h3: hz = 32'd16000000;
      3'h4: hz = 32'd19200000;
      3'h5: hz = 32'd19680000;
      3'h6: hz = 32'd24000000;
      default: hz = 32'd24576000;
    endcase
    return hz;
  endfunction

  // Frame period in clk cycles to rate code, either family, within tolerance
  function automatic ascc_code_t rateCodeOf(input logic [16:0] period);
    logic [63:0] prod;
    logic [63:0] lo;
    logic [63:0] hi;
    ascc_code_t code;
    code = `ASCC_CODE_INVALID;
    lo = 64'(`ASCC_CLK_HZ) * 64'(32'd100 - `ASCC_RATE_TOL_PCT);
    hi = 64'(`ASCC_CLK_HZ) * 64'(32'd100 + `ASCC_RATE_TOL_PCT);
    for (int k = 0; k <= 8; k++)
    begin
      for (int f = 0; f <= 1; f++)
      begin
        prod = 64'(period) * 64'(rateHz(4'(k), f == 1)) * 64'd100;
        if (prod >= lo && prod <= hi)
        begin
          code = 4'(k);
        end
      end
    end
    return code;
  endfunction

  function automatic ascc_code_t ratioCodeOf(input ascc_count_t cnt);
    ascc_code_t code;
    code = `ASCC_CODE_INVALID;
    for (int k = 0; k <= 12; k++)
    begin
      if (bitRatio(4'(k)) == cnt)
      begin
        code = 4'(k);
      end
    end
    return code;
  endfunction

  ascc_mon_if monLink ();

  ascc_link_monitor linkMonitor (
    .bitClk(bitClkIn),
    .rstn(rstn),
    .frameSyncIn(frameSyncIn),
    .mon(monLink.mon)
  );

  ascc_byte_t masterRate_reg;
  ascc_clock_source_config_s clockSrc_reg;
  ascc_code_t rateSts_reg;
  ascc_code_t ratioSts_reg;
  logic tgS1_reg;
  logic tgS2_reg;
  logic tgS3_reg;
  logic tgSeen_reg;
  logic [16:0] perCnt_reg;
  logic perValid_reg;
  logic [33:0] step_reg;
  logic [33:0] acc_reg;
  ascc_count_t bitIdx_reg;
  logic frameEvt;
  logic timedOut;
  logic genOn;
  logic tick;
  logic launch;
  logic [33:0] accSum;
  logic [19:0] progHz;
  ascc_count_t progRatio;
  ascc_code_t rateCode;
  ascc_code_t ratioCode;

  assign rateCode = masterRate_reg[`ASCC_RATE_MSB:`ASCC_RATE_LSB];
  assign ratioCode = masterRate_reg[`ASCC_RATIO_MSB:`ASCC_RATIO_LSB];
  assign progHz = rateHz(rateCode, rateFamilySelect);
  assign progRatio = bitRatio(ratioCode);

  // Register writes; status is read only
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      masterRate_reg <= `ASCC_RST_MASTER_RATE;
      clockSrc_reg <= ascc_clock_source_config_s'(`ASCC_RST_CLOCK_SRC);
    end
    else if (regWrEn && regAddr == `ASCC_ADDR_MASTER_RATE)
    begin
      masterRate_reg <= regWrData;
    end
    else if (regWrEn && regAddr == `ASCC_ADDR_CLOCK_SRC)
    begin
      clockSrc_reg <= ascc_clock_source_config_s'(regWrData);
    end
  end

  // Register reads, one cycle after the address
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      regRdData <= 8'h00;
    end
    else
    begin
      case (regAddr)
        `ASCC_ADDR_MASTER_RATE: regRdData <= masterRate_reg;
        `ASCC_ADDR_MONITOR_STS: regRdData <= {rateSts_reg, ratioSts_reg};
        `ASCC_ADDR_CLOCK_SRC: regRdData <= 8'(clockSrc_reg);
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // Frame event from the link domain, counted once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tgS1_reg <= 1'b0;
      tgS2_reg <= 1'b0;
      tgS3_reg <= 1'b0;
      tgSeen_reg <= 1'b0;
    end
    else
    begin
      tgS1_reg <= monLink.frameToggle;
      tgS2_reg <= tgS1_reg;
      tgS3_reg <= tgS2_reg;
      if (frameEvt)
      begin
        tgSeen_reg <= tgS3_reg;
      end
    end
  end

  assign frameEvt = (tgS2_reg == tgS3_reg) && (tgS3_reg != tgSeen_reg);
  assign timedOut = perCnt_reg >= 17'(FRAME_TIMEOUT_CYC);

  // Frame period measured in clk cycles
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      perCnt_reg <= 17'h0_0000;
      perValid_reg <= 1'b0;
    end
    else if (frameEvt)
    begin
      perCnt_reg <= 17'h0_0001;
      perValid_reg <= 1'b1;
    end
    else if (timedOut)
    begin
      perValid_reg <= 1'b0;
    end
    else
    begin
      perCnt_reg <= perCnt_reg + 17'h0_0001;
    end
  end

  // Detected rate and ratio status
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rateSts_reg <= `ASCC_CODE_INVALID;
      ratioSts_reg <= `ASCC_CODE_INVALID;
    end
    else if (timedOut)
    begin
      rateSts_reg <= `ASCC_CODE_INVALID;
      ratioSts_reg <= `ASCC_CODE_INVALID;
    end
    else if (frameEvt)
    begin
      rateSts_reg <= perValid_reg ? rateCodeOf(perCnt_reg) : `ASCC_CODE_INVALID;
      ratioSts_reg <= ratioCodeOf(monLink.ratioCount);
    end
  end

  // Master generator runs only on supported codes
  assign genOn = masterSlaveSelect && rateCode <= `ASCC_RATE_CODE_MAX
    && ratioCode <= `ASCC_RATIO_CODE_MAX;
  assign accSum = acc_reg + step_reg;
  assign tick = genOn && accSum >= 34'(`ASCC_CLK_HZ);
  // Frame sync launches on the falling bit clock edge, or the rising one when inverted
  assign launch = tick && (clockSrc_reg.invertBitClk ? !bitClkOut : bitClkOut);

  // Half-periods of the bit clock at twice frame rate times ratio
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      step_reg <= 34'h0_0000_0000;
      acc_reg <= 34'h0_0000_0000;
      bitClkOut <= 1'b0;
    end
    else
    begin
      step_reg <= 34'(progHz) * 34'(progRatio) * 34'h0_0000_0002;
      if (!genOn)
      begin
        acc_reg <= 34'h0_0000_0000;
        bitClkOut <= 1'b0;
      end
      else if (tick)
      begin
        acc_reg <= accSum - 34'(`ASCC_CLK_HZ);
        bitClkOut <= !bitClkOut;
      end
      else
      begin
        acc_reg <= accSum;
      end
    end
  end

  // Frame sync high for one bit in every ratio bits
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bitIdx_reg <= 12'h000;
      frameSyncOut <= 1'b0;
    end
    else if (!genOn)
    begin
      bitIdx_reg <= progRatio - 12'h001;
      frameSyncOut <= 1'b0;
    end
    else if (launch)
    begin
      bitIdx_reg <= (bitIdx_reg >= progRatio - 12'h001) ? 12'h000 : bitIdx_reg + 12'h001;
      frameSyncOut <= bitIdx_reg >= progRatio - 12'h001;
    end
  end

  // Pin direction
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bitClkOe <= 1'b0;
      frameSyncOe <= 1'b0;
    end
    else
    begin
      bitClkOe <= masterSlaveSelect;
      frameSyncOe <= masterSlaveSelect;
    end
  end

  // Root clock source and reference frequency
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rootUsesRef <= 1'b0;
      refRatioValue <= 12'h000;
      refFreqHz <= 32'h0000_0000;
    end
    else
    begin
      rootUsesRef <= !masterSlaveSelect && autoClkCfgOn && autoPllDisable
        && clockSrc_reg.rootSrcRef;
      refRatioValue <= refRatio(clockSrc_reg.refRatioSel);
      if (masterSlaveSelect && autoClkCfgOn)
      begin
        refFreqHz <= clockSrc_reg.refFreqFromRatio
          ? 32'(progHz) * 32'(refRatio(clockSrc_reg.refRatioSel))
          : fixedRefHz(refFixedFreqSelect);
      end
      else
      begin
        refFreqHz <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/ascc_clock_config_assertions.sv */
// Port assertions for ascc_clock_config
// Bound from the testbench top; one clock domain
`timescale 1ns/1ns
`default_nettype none
module ascc_checker
  import ascc_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT_CYC = 34000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire ascc_pkg::ascc_addr_t regAddr,
  input wire logic regWrEn,
  input wire ascc_pkg::ascc_byte_t regWrData,
  input wire ascc_pkg::ascc_byte_t regRdData,
  // Mode inputs
  input wire logic masterSlaveSelect,
  input wire logic autoClkCfgOn,
  input wire logic autoPllDisable,
  // Pins and settings
  input wire logic frameSyncIn,
  input wire logic bitClkOut,
  input wire logic bitClkOe,
  input wire logic frameSyncOut,
  input wire logic frameSyncOe,
  input wire logic rootUsesRef
);
  ascc_byte_t rateCfg_reg;
  ascc_byte_t srcCfg_reg;
  logic [15:0] quiet_reg;
  logic genOff;
  logic rootExp;
  assign genOff = !masterSlaveSelect || rateCfg_reg[7:4] > 4'h8 || rateCfg_reg[3:0] > 4'hC;
  assign rootExp = !masterSlaveSelect && autoClkCfgOn && autoPllDisable && srcCfg_reg[7];
  always_ff @(posedge clk)
    if (!rstn)
      rateCfg_reg <= 8'h48;
    else if (regWrEn && regAddr == 8'h14)
      rateCfg_reg <= regWrData;
  always_ff @(posedge clk)
    if (!rstn)
      srcCfg_reg <= 8'h10;
    else if (regWrEn && regAddr == 8'h16)
      srcCfg_reg <= regWrData;
  // Cycles since the frame sync pin last moved
  always_ff @(posedge clk)
    if (!rstn || $changed(frameSyncIn))
      quiet_reg <= 16'h0000;
    else if (quiet_reg != 16'hFFFF)
      quiet_reg <= quiet_reg + 16'h0001;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  oe_follows_mode_a: assert property ($past(rstn, 3) |-> bitClkOe == $past(masterSlaveSelect))
    else $error("bit clock enable does not follow mode");
  oe_pair_a: assert property (frameSyncOe == bitClkOe)
    else $error("pin enables differ");
  idle_quiet_a: assert property ($past(genOff, 2) && $past(genOff) && genOff |-> !bitClkOut && !frameSyncOut)
    else $error("generator active while off");
  launch_edge_a: assert property (!$past(genOff, 2) && !$past(genOff) && !genOff && $changed(frameSyncOut)
    |-> (srcCfg_reg[1] ? $rose(bitClkOut) : $fell(bitClkOut)))
    else $error("frame sync moved off its launch edge");
  cfg_readback_a: assert property ($past(rstn) && $past(regAddr) == 8'h14 |-> regRdData == $past(rateCfg_reg))
    else $error("rate config read back wrong");
  unmapped_zero_a: assert property ($past(rstn) && !($past(regAddr) inside {8'h14, 8'h15, 8'h16})
    |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  status_codes_a: assert property ($past(rstn) && $past(regAddr) == 8'h15
    |-> (regRdData[7:4] <= 4'h8 || regRdData[7:4] == 4'hF) && (regRdData[3:0] <= 4'hC || regRdData[3:0] == 4'hF))
    else $error("reserved status code");
  timeout_invalid_a: assert property ($past(rstn) && $past(regAddr) == 8'h15 && quiet_reg > FRAME_TIMEOUT_CYC + 40
    |-> regRdData == 8'hFF)
    else $error("status kept after clocks stopped");
  root_source_a: assert property ($past(rstn, 2) && $stable(rootExp) |-> rootUsesRef == rootExp)
    else $error("root source select wrong");
endmodule
`default_nettype wire

/* tb/ascc_host_model.sv */
// Audio host driving bit clock and frame sync while the block is slave
// Bit clock of 15 ns stands still low between frames
`timescale 1ns/1ns
`default_nettype none
module ascc_host_model
(
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] periodNs,
  input wire logic [15:0] bits,
  // Bus pins
  output logic bitClk,
  output logic frameSync
);
  initial
  begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    #3;
    forever
    begin
      if (!run)
        #15;
      else
      begin
        for (int i = 0; i < int'(bits); i++)
        begin
          frameSync = (i == 0);
          #7 bitClk = 1'b1;
          #8 bitClk = 1'b0;
        end
        frameSync = 1'b0;
        #(int'(periodNs) - int'(bits) * 15);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_audio_serial_clock_config.sv */
// Self-checking testbench for ascc_clock_config
// Needs the host model and the checker; pins resolved from the enables
`timescale 1ns/1ns
`default_nettype none
module test_audio_serial_clock_config;
  import ascc_pkg::*;
  localparam int unsigned TOUT = 4000;
  logic clk;
  logic rstn = 1'b0;
  ascc_addr_t regAddr = 8'h00;
  logic regWrEn = 1'b0;
  ascc_byte_t regWrData = 8'h00;
  ascc_byte_t regRdData;
  logic masterSlaveSelect = 1'b0;
  logic autoClkCfgOn = 1'b1;
  logic autoPllDisable = 1'b0;
  logic rateFamilySelect = 1'b0;
  logic [2:0] refFixedFreqSelect = 3'h0;
  logic bitClkOut, bitClkOe, frameSyncOut, frameSyncOe, rootUsesRef, hostClk, hostFs, lvl;
  ascc_count_t refRatioValue;
  logic [31:0] refFreqHz;
  // Host clocks run during reset so the link side sees its own reset
  logic hostRun = 1'b1;
  logic [15:0] hostPeriod = 16'd20833;
  logic [15:0] hostBits = 16'd64;
  wire bitClkPin;
  wire frameSyncPin;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'haef652de;
  ascc_byte_t v, d, a;
  logic [31:0] r;
  int cyc, bits, k, j;
  int refTab[8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
  int freqTab[8] = '{12000000, 12288000, 13000000, 16000000, 19200000, 19680000, 24000000, 24576000};
  int ratioTab[8] = '{16, 24, 32, 48, 64, 96, 128, 192};
  int perTab[4] = '{20833, 10417, 5208, 22676};
  int bitTab[4] = '{64, 32, 256, 192};
  int stsTab[4] = '{8'h44, 8'h52, 8'h68, 8'h47};
  assign bitClkPin = bitClkOe ? bitClkOut : hostClk;
  assign frameSyncPin = frameSyncOe ? frameSyncOut : hostFs;
  ascc_clock_config #(.FRAME_TIMEOUT_CYC(TOUT)) DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .masterSlaveSelect(masterSlaveSelect),
    .autoClkCfgOn(autoClkCfgOn), .autoPllDisable(autoPllDisable), .rateFamilySelect(rateFamilySelect),
    .refFixedFreqSelect(refFixedFreqSelect), .bitClkIn(bitClkPin), .bitClkOut(bitClkOut), .bitClkOe(bitClkOe),
    .frameSyncIn(frameSyncPin), .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe),
    .rootUsesRef(rootUsesRef), .refRatioValue(refRatioValue), .refFreqHz(refFreqHz));
  ascc_host_model host (.run(hostRun), .periodNs(hostPeriod), .bits(hostBits), .bitClk(hostClk),
    .frameSync(hostFs));
  function automatic int fsOf(input int fam);
    return fam ? 44100 : 48000;
  endfunction
  function automatic int fsCyc(input int fam);
    return 125000000 / fsOf(fam);
  endfunction
  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input ascc_addr_t adr, input ascc_byte_t dat);
    @(posedge clk);
    regAddr <= adr;
    regWrEn <= 1'b1;
    regWrData <= dat;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input ascc_addr_t adr, output ascc_byte_t dat);
    @(posedge clk);
    regAddr <= adr;
    @(posedge clk);
    #1 dat = regRdData;
  endtask
  // Cycles and bit clocks between two frame starts, bit clock level at the start
  task automatic measure(output int c, output int b, output logic l);
    logic fp, bp;
    int n;
    fp = frameSyncOut;
    bp = bitClkOut;
    n = 0;
    c = 0;
    b = 0;
    while (n < 2)
    begin
      @(posedge clk);
      #1;
      if (n == 1)
      begin
        c++;
        if (bitClkOut && !bp)
          b++;
      end
      if (frameSyncOut && !fp)
      begin
        n++;
        l = bitClkOut;
      end
      fp = frameSyncOut;
      bp = bitClkOut;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    hostRun <= 1'b0;
    rd(8'h14, v);
    check("rate cfg reset", v, 8'h48);
    rd(8'h15, v);
    check("status reset", v, 8'hFF);
    rd(8'h16, v);
    check("source cfg reset", v, 8'h10);
    wr(8'h15, 8'h00);
    rd(8'h15, v);
    check("status read only", v, 8'hFF);
    repeat (6)
    begin
      r = $random(seed);
      d = {4'(r[15:0] % 9), 4'(r[31:16] % 13)};
      wr(8'h14, d);
      rd(8'h14, v);
      check("rate cfg", v, d);
      a = 8'h17 + {2'b00, r[5:0]};
      wr(a, r[7:0]);
      rd(a, v);
      check("unmapped", v, 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h16, {2'b00, 3'(i), 3'b000});
      rd(8'h16, v);
      check("source cfg", v, {2'b00, 3'(i), 3'b000});
      check("ref ratio", refRatioValue, refTab[i]);
    end
    @(posedge clk);
    masterSlaveSelect <= 1'b1;
    wr(8'h14, 8'h44);
    wr(8'h16, 8'h10);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      refFixedFreqSelect <= 3'(i);
      repeat (3) @(posedge clk);
      #1 check("fixed ref", refFreqHz, freqTab[i]);
    end
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk);
      rateFamilySelect <= f[0];
      wr(8'h16, 8'h50);
      rd(8'h16, v);
      check("ratio ref", refFreqHz, fsOf(f) * 384);
      r = $random(seed);
      wr(8'h14, {5'h08, r[2:0]});
      measure(cyc, bits, lvl);
      measure(cyc, bits, lvl);
      check("bits per frame", bits, ratioTab[r[2:0]]);
      check("frame period", cyc >= fsCyc(f) - 2 && cyc <= fsCyc(f) + 2, 1);
      check("launch edge", lvl, 1'b0);
      rd(8'h15, v);
      check("master status", v, {5'h08, r[2:0]});
    end
    masterSlaveSelect <= 1'b0;
    wr(8'h16, 8'h52);
    @(posedge clk);
    masterSlaveSelect <= 1'b1;
    measure(cyc, bits, lvl);
    measure(cyc, bits, lvl);
    check("inverted launch", lvl, 1'b1);
    check("inverted bits", bits, ratioTab[r[2:0]]);
    @(posedge clk);
    masterSlaveSelect <= 1'b0;
    autoPllDisable <= 1'b1;
    wr(8'h16, 8'h90);
    rd(8'h16, v);
    check("root ref", rootUsesRef, 1'b1);
    check("ref off", refFreqHz, 0);
    autoClkCfgOn <= 1'b0;
    rd(8'h16, v);
    check("root manual", rootUsesRef, 1'b0);
    autoClkCfgOn <= 1'b1;
    wr(8'h16, 8'h10);
    rd(8'h16, v);
    check("root bit clock", rootUsesRef, 1'b0);
    k = $unsigned($random(seed)) % 4;
    for (int i = 0; i < 4; i++)
    begin
      j = (k + i) % 4;
      @(posedge clk);
      hostPeriod <= 16'(perTab[j]);
      hostBits <= 16'(bitTab[j]);
      hostRun <= 1'b1;
      repeat (perTab[j] / 2) @(posedge clk);
      rd(8'h15, v);
      check("detected", v, stsTab[j]);
    end
    @(posedge clk);
    hostRun <= 1'b0;
    repeat (2 * TOUT) @(posedge clk);
    rd(8'h15, v);
    check("timeout", v, 8'hFF);
    test_done();
  end
endmodule
bind ascc_clock_config ascc_checker #(.FRAME_TIMEOUT_CYC(FRAME_TIMEOUT_CYC)) chk (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
  .masterSlaveSelect(masterSlaveSelect), .autoClkCfgOn(autoClkCfgOn), .autoPllDisable(autoPllDisable),
  .frameSyncIn(frameSyncIn), .bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .frameSyncOut(frameSyncOut),
  .frameSyncOe(frameSyncOe), .rootUsesRef(rootUsesRef));
`default_nettype wire
